/* src/iep_pkg.sv */
// Purpose: Shared constants and helpers for the interrupt priority core
// Assumes: Eight request levels, 32-bit register bus
// Notes: Level n has rank (n - lowest - 1) mod 8, rank 0 wins
package iep_pkg;
  localparam int IEP_AW = 8;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] IEP_OFS_CTRL = 8'h00;
  localparam logic [7:0] IEP_OFS_CMD = 8'h04;
  localparam logic [7:0] IEP_OFS_MASK = 8'h08;
  localparam logic [7:0] IEP_OFS_STAT = 8'h0C;
  localparam logic [7:0] IEP_OFS_ISTAT = 8'h10;
  localparam logic [7:0] IEP_OFS_IMASK = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IEP_CTRL_AEOS = 0;
  localparam int IEP_CTRL_C16 = 1;
  localparam int IEP_CTRL_RAUTO = 2;
  localparam int IEP_ST_ISR = 8;
  localparam int IEP_ST_LOW = 16;
  localparam int IEP_ST_INT = 19;
  localparam int IEP_ST_CNT = 20;
  localparam int IEP_CMD_OP = 4;
  localparam int IEP_EV_ACK = 0;
  localparam int IEP_EV_INT = 1;
  localparam int IEP_EV_ROT = 2;
  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [7:0] IEP_MASK_RST = 8'h00;
  localparam logic [2:0] IEP_LOWEST_RST = 3'h7;
  localparam logic [2:0] IEP_DEFAULT_LVL = 3'h7;
  localparam logic [1:0] IEP_PULSES_8B = 2'h3;
  localparam logic [1:0] IEP_PULSES_16B = 2'h2;
  localparam logic [1:0] IEP_RESP_OK = 2'h0;
  localparam logic [1:0] IEP_RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    IEP_OP_NOP = 3'b000,
    IEP_OP_EOS_NS = 3'b001,
    IEP_OP_EOS_SP = 3'b010,
    IEP_OP_ROT_NS = 3'b011,
    IEP_OP_SET_PRI = 3'b100,
    IEP_OP_ROT_SP = 3'b101,
    IEP_OP_RAUTO_SET = 3'b110,
    IEP_OP_RAUTO_CLR = 3'b111
  } iep_op_e;
  typedef enum logic [2:0] {
    IEP_R_CTRL = 3'b000,
    IEP_R_CMD = 3'b001,
    IEP_R_MASK = 3'b010,
    IEP_R_STAT = 3'b011,
    IEP_R_ISTAT = 3'b100,
    IEP_R_IMASK = 3'b101,
    IEP_R_NONE = 3'b111
  } iep_reg_e;
  function automatic iep_reg_e iep_sel(input logic [IEP_AW-1:0] a);
    case (a)
      IEP_OFS_CTRL: return IEP_R_CTRL;
      IEP_OFS_CMD: return IEP_R_CMD;
      IEP_OFS_MASK: return IEP_R_MASK;
      IEP_OFS_STAT: return IEP_R_STAT;
      IEP_OFS_ISTAT: return IEP_R_ISTAT;
      IEP_OFS_IMASK: return IEP_R_IMASK;
      default: return IEP_R_NONE;
    endcase
  endfunction : iep_sel
  function automatic logic [2:0] iep_rank(input logic [2:0] lvl, input logic [2:0] low);
    return 3'(lvl - low - 3'h1);
  endfunction : iep_rank
endpackage : iep_pkg

/* src/iep_pri_if.sv */
// Purpose: Carries vectors to the priority resolver and its verdict back
// Assumes: Single clock, purely combinational resolver
// Notes: None
`timescale 1ns/1ns
interface iep_pri_if;
  logic [2:0] lowest;
  logic [7:0] req_vec;
  logic [7:0] isr_vec;
  logic [2:0] req_win;
  logic req_ok;
  logic [2:0] isr_top;
  logic isr_any;
  logic grant;
  modport core (output lowest, output req_vec, output isr_vec,
    input req_win, input req_ok, input isr_top, input isr_any, input grant);
  modport res (input lowest, input req_vec, input isr_vec,
    output req_win, output req_ok, output isr_top, output isr_any, output grant);
endinterface : iep_pri_if

/* src/iep_resolve.sv */
// Purpose: Circular priority resolver for requests and in-service bits
// Assumes: Level after lowest is highest
// Notes: Default level returned when nothing pending
`timescale 1ns/1ns
module iep_resolve (
  iep_pri_if.res pri
);
  import iep_pkg::*;
  logic [2:0] lvl;
  always_comb begin
    pri.req_ok = 1'b0;
    pri.req_win = IEP_DEFAULT_LVL;
    pri.isr_any = 1'b0;
    pri.isr_top = IEP_DEFAULT_LVL;
    lvl = 3'h0;
    // Walk ranks low priority to high, last hit wins
    for (int r = 7; r >= 0; r--) begin
      lvl = 3'(pri.lowest + 3'(r) + 3'h1);
      if (pri.req_vec[lvl]) begin
        pri.req_ok = 1'b1;
        pri.req_win = lvl;
      end
      if (pri.isr_vec[lvl]) begin
        pri.isr_any = 1'b1;
        pri.isr_top = lvl;
      end
    end
    // Equal or lower levels blocked by service
    pri.grant = pri.req_ok && (!pri.isr_any ||
      (iep_rank(pri.req_win, pri.lowest) < iep_rank(pri.isr_top, pri.lowest)));
  end
endmodule : iep_resolve

/* src/iep_top.sv */
// How it works
// - Auto mode: non-specific end at trailing edge of last acknowledge pulse
// - Auto mode frees the in-service bit right after acknowledge
// - Rotate non-specific: clear top in-service bit, make it lowest
// - Rotate-auto setting rotates after each final acknowledge pulse
// - Set priority makes named level lowest, in-service untouched
// - Priority resolved only on request arrival or removal, acknowledge activity or end-of-service commands
// - Rotate specific clears named bit and makes that level lowest
// - Eight-bit mask, one bit per input, one masks
// - Mask gates latch outputs only, latch still sets
// - Unmasking a pending active request raises an interrupt
// - Request gone before unmask gives no interrupt
// - Reset gives level 0 highest, level 7 lowest
// - Acknowledge sets in-service bit, blocking equal or lower levels
// - Non-specific end clears top bit, specific clears named bit
//
// Purpose: Priority, end-of-service and mask core with AXI4-Lite access
// Assumes: Level requests, active high acknowledge strobe
// Notes: Commands written to the command register
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module iep_top (
  input logic aclk,
  input logic aresetn,
  input logic [iep_pkg::IEP_AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [iep_pkg::IEP_AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [7:0] request_inputs,
  input logic interrupt_acknowledge_strobe,
  output logic int_req,
  output logic [2:0] ack_level,
  output logic irq
);
  import iep_pkg::*;
  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic aw_got, w_got;
    logic [IEP_AW-1:0] waddr;
    logic [31:0] wdata;
    logic wlane0;
    logic [7:0] req_s1, req_s2, latch, gated_prev, mask, in_service_bits;
    logic ack_s1, ack_s2, ack_s3;
    logic [1:0] ack_cnt;
    logic [2:0] ack_level, lowest;
    logic auto_eos, cpu16, rot_auto, int_req, eval_pend;
    logic [2:0] ev, ev_mask;
    logic irq;
  } iep_st_s;
  localparam iep_st_s ST_RST = '{lowest: IEP_LOWEST_RST, mask: IEP_MASK_RST,
    default: '0};
  iep_st_s r;
  iep_st_s n;
  iep_pri_if pri();
  logic [7:0] gated, isr_top_oh, win_oh, lvl_oh, isr_clr, isr_set;
  logic [2:0] cmd_lvl, ev_set;
  logic [1:0] fin_cnt;
  logic ack_rise, ack_fall, ack_first, fin, aeos_act, do_wr, cmd_go, eos_cmd;
  iep_op_e op;
  iep_reg_e wsel;
  iep_reg_e rsel;
  // ----------------------------------------
  // Resolver
  // ----------------------------------------
  assign gated = r.latch & ~r.mask;
  assign pri.lowest = r.lowest;
  assign pri.req_vec = gated;
  assign pri.isr_vec = r.in_service_bits;
  iep_resolve u_res (
    .pri(pri.res)
  );
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    isr_top_oh = 8'h01 << pri.isr_top;
    win_oh = 8'h01 << pri.req_win;
    cmd_lvl = r.wdata[2:0];
    lvl_oh = 8'h01 << cmd_lvl;
    op = iep_op_e'(r.wdata[IEP_CMD_OP+2:IEP_CMD_OP]);
    wsel = iep_sel(r.waddr);
    rsel = iep_sel(s_axi_araddr);
    isr_clr = 8'h00;
    isr_set = 8'h00;
    ev_set = 3'h0;
    // Input synchronisers
    n.req_s1 = request_inputs;
    n.req_s2 = r.req_s1;
    n.ack_s1 = interrupt_acknowledge_strobe;
    n.ack_s2 = r.ack_s1;
    n.ack_s3 = r.ack_s2;
    n.latch = r.req_s2;
    n.gated_prev = gated;
    // Acknowledge pulse tracking
    ack_rise = r.ack_s2 && !r.ack_s3;
    ack_fall = !r.ack_s2 && r.ack_s3;
    fin_cnt = r.cpu16 ? IEP_PULSES_16B : IEP_PULSES_8B;
    ack_first = ack_rise && (r.ack_cnt == 2'h0);
    fin = ack_fall && (r.ack_cnt == fin_cnt);
    aeos_act = r.auto_eos || r.rot_auto;
    if (ack_rise && !fin) begin
      n.ack_cnt = 2'(r.ack_cnt + 2'h1);
    end
    if (ack_first) begin
      isr_set = win_oh;
      n.ack_level = pri.req_win;
    end
    if (fin) begin
      n.ack_cnt = 2'h0;
      ev_set[IEP_EV_ACK] = 1'b1;
      if (aeos_act) begin
        isr_clr = isr_top_oh;
      end
      if (r.rot_auto && pri.isr_any) begin
        n.lowest = pri.isr_top;
        ev_set[IEP_EV_ROT] = 1'b1;
      end
    end
    // AXI write channel
    if (s_axi_awvalid && r.awready) begin
      n.aw_got = 1'b1;
      n.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wlane0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    do_wr = r.aw_got && r.w_got && !r.bvalid;
    cmd_go = do_wr && r.wlane0 && (wsel == IEP_R_CMD);
    eos_cmd = 1'b0;
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wsel == IEP_R_NONE) ? IEP_RESP_ERR : IEP_RESP_OK;
    end
    if (do_wr && r.wlane0) begin
      case (wsel)
        IEP_R_CTRL: begin
          n.auto_eos = r.wdata[IEP_CTRL_AEOS];
          n.cpu16 = r.wdata[IEP_CTRL_C16];
        end
        IEP_R_MASK: n.mask = r.wdata[7:0];
        IEP_R_IMASK: n.ev_mask = r.wdata[2:0];
        default: n.ev_mask = n.ev_mask;
      endcase
    end
    // Commands
    if (cmd_go) begin
      case (op)
        IEP_OP_EOS_NS: begin
          isr_clr = isr_clr | isr_top_oh;
          eos_cmd = 1'b1;
        end
        IEP_OP_EOS_SP: begin
          isr_clr = isr_clr | lvl_oh;
          eos_cmd = 1'b1;
        end
        IEP_OP_ROT_NS: begin
          eos_cmd = 1'b1;
          if (pri.isr_any) begin
            isr_clr = isr_clr | isr_top_oh;
            n.lowest = pri.isr_top;
            ev_set[IEP_EV_ROT] = 1'b1;
          end
        end
        IEP_OP_SET_PRI: begin
          n.lowest = cmd_lvl;
          ev_set[IEP_EV_ROT] = 1'b1;
        end
        IEP_OP_ROT_SP: begin
          isr_clr = isr_clr | lvl_oh;
          n.lowest = cmd_lvl;
          eos_cmd = 1'b1;
          ev_set[IEP_EV_ROT] = 1'b1;
        end
        IEP_OP_RAUTO_SET: n.rot_auto = 1'b1;
        IEP_OP_RAUTO_CLR: n.rot_auto = 1'b0;
        default: eos_cmd = 1'b0;
      endcase
    end
    // Set wins over clear
    n.in_service_bits = (r.in_service_bits & ~isr_clr) | isr_set;
    // Resolve only on arrivals, removals, acknowledge activity and end-of-service commands
    n.eval_pend = (|(gated & ~r.gated_prev)) || (|(r.gated_prev & ~gated)) ||
      ack_first || fin || eos_cmd;
    if (r.eval_pend) begin
      n.int_req = pri.grant && (r.ack_cnt == 2'h0);
    end
    if (ack_first) begin
      n.int_req = 1'b0;
    end
    ev_set[IEP_EV_INT] = n.int_req && !r.int_req;
    // Read channel
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = (rsel == IEP_R_NONE) ? IEP_RESP_ERR : IEP_RESP_OK;
      n.rdata = 32'h0000_0000;
      case (rsel)
        IEP_R_CTRL: begin
          n.rdata[IEP_CTRL_AEOS] = r.auto_eos;
          n.rdata[IEP_CTRL_C16] = r.cpu16;
          n.rdata[IEP_CTRL_RAUTO] = r.rot_auto;
        end
        IEP_R_MASK: n.rdata[7:0] = r.mask;
        IEP_R_STAT: begin
          n.rdata[7:0] = r.latch;
          n.rdata[IEP_ST_ISR+7:IEP_ST_ISR] = r.in_service_bits;
          n.rdata[IEP_ST_LOW+2:IEP_ST_LOW] = r.lowest;
          n.rdata[IEP_ST_INT] = r.int_req;
          n.rdata[IEP_ST_CNT+1:IEP_ST_CNT] = r.ack_cnt;
        end
        IEP_R_ISTAT: n.rdata[2:0] = r.ev;
        IEP_R_IMASK: n.rdata[2:0] = r.ev_mask;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // Event status, write one clears, set wins
    if (do_wr && r.wlane0 && (wsel == IEP_R_ISTAT)) begin
      n.ev = r.ev & ~r.wdata[2:0];
    end
    n.ev = n.ev | ev_set;
    n.irq = |(n.ev & n.ev_mask);
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign int_req = r.int_req;
  assign ack_level = r.ack_level;
  assign irq = r.irq;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_AEOS_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (fin && aeos_act) |=> ((r.in_service_bits & $past(isr_top_oh)) == 8'h00))
    else $error("auto end did not clear in-service bit");
  AST_AEOS_FREE: assert property (@(posedge aclk) disable iff (!aresetn)
    (fin && aeos_act && !cmd_go) |=> (r.in_service_bits == ($past(r.in_service_bits) & ~$past(isr_top_oh))))
    else $error("auto end left wrong in-service state");
  AST_ROT_NS: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_go && op == IEP_OP_ROT_NS && pri.isr_any && !fin && !ack_first)
    |=> (r.lowest == $past(pri.isr_top)) && !r.in_service_bits[$past(pri.isr_top)])
    else $error("rotate non-specific wrong");
  AST_AUTO_ROT: assert property (@(posedge aclk) disable iff (!aresetn)
    (fin && r.rot_auto && pri.isr_any && !cmd_go) |=> (r.lowest == $past(pri.isr_top)))
    else $error("automatic rotation missing");
  AST_SET_PRI: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_go && op == IEP_OP_SET_PRI && !ack_first && !fin)
    |=> (r.lowest == $past(cmd_lvl)) && $stable(r.in_service_bits))
    else $error("set priority wrong");
  AST_HOLD_INT: assert property (@(posedge aclk) disable iff (!aresetn)
    (!r.eval_pend && !ack_first) |=> $stable(r.int_req))
    else $error("interrupt changed without resolution");
  AST_ROT_SP: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_go && op == IEP_OP_ROT_SP && !ack_first)
    |=> (r.lowest == $past(cmd_lvl)) && !r.in_service_bits[$past(cmd_lvl)])
    else $error("rotate specific wrong");
  AST_MASK_WR: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && r.wlane0 && wsel == IEP_R_MASK) |=> (r.mask == $past(r.wdata[7:0])))
    else $error("mask write lost");
  AST_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (r.latch == $past(r.req_s2)))
    else $error("latch not following input");
  AST_UNMASK: assert property (@(posedge aclk) disable iff (!aresetn)
    ((|(gated & ~r.gated_prev)) && !pri.isr_any && (r.ack_cnt == 2'h0) && !ack_rise)
    ##1 ((gated != 8'h00) && !ack_first) |=> r.int_req)
    else $error("unmasked request not raised");
  AST_GONE: assert property (@(posedge aclk) disable iff (!aresetn)
    (gated == 8'h00) [*2] |=> !r.int_req)
    else $error("interrupt without pending request");
  AST_RST_PRI: assert property (@(posedge aclk)
    !aresetn |=> (r.lowest == IEP_LOWEST_RST) && (r.in_service_bits == 8'h00))
    else $error("reset priority wrong");
  AST_ISR_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_first |=> ((r.in_service_bits & $past(win_oh)) != 8'h00) && !r.int_req)
    else $error("acknowledge did not set in-service");
  AST_SPEC_EOS: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_go && op == IEP_OP_EOS_SP && !ack_first) |=> !r.in_service_bits[$past(cmd_lvl)])
    else $error("specific end did not clear");
endmodule : iep_top

/* bench/iep_host_model.sv */
// Purpose: Host side model running acknowledge pulse sequences
// Assumes: Pulses 4 clocks high and 4 clocks low
// Notes: Acknowledges only when the bench tells it to
`timescale 1ns/1ns
module iep_host_model (
  input logic aclk,
  input logic go,
  input logic [1:0] npulse,
  output logic strobe,
  output logic busy
);
  // ----------------------------------------
  // Pulse sequencer
  // ----------------------------------------
  initial begin
    strobe = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        repeat (npulse) begin
          repeat (4) @(posedge aclk);
          strobe <= 1'b1;
          repeat (4) @(posedge aclk);
          strobe <= 1'b0;
        end
        repeat (6) @(posedge aclk);
        busy <= 1'b0;
      end
    end
  end
endmodule : iep_host_model

/* bench/iep_top_tb.sv */
// Purpose: Self-checking bench for the priority core
// Assumes: Register access over AXI4-Lite, host model for acknowledges
// Notes: Level requests driven directly by the bench
`timescale 1ns/1ns
module iep_top_tb;
  import iep_pkg::*;
  logic aclk, aresetn, awv, wv, br, arv, rr, go, busy, stb;
  logic awr, wrdy, bv, arr, rv, int_req, irq;
  logic [7:0] aa, ra, req;
  logic [31:0] wd, rdat, rd_v;
  logic [1:0] bresp, rresp, bres, rres, np;
  logic [2:0] ack_level;
  int err_count, checks, cyc;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  iep_top i_iep_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .request_inputs(req), .interrupt_acknowledge_strobe(stb),
    .int_req(int_req), .ack_level(ack_level), .irq(irq));
  iep_host_model i_iep_host_model (.aclk(aclk), .go(go), .npulse(np),
    .strobe(stb), .busy(busy));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim;
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    @(posedge aclk);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awr === 1'b1) begin
        awv <= 1'b0;
        ad = 1'b1;
      end
      if (!dd && wrdy === 1'b1) begin
        wv <= 1'b0;
        dd = 1'b1;
      end
    end
    while (bv !== 1'b1) @(posedge aclk);
    bres = bresp;
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    @(posedge aclk);
    while (arr !== 1'b1) @(posedge aclk);
    arv <= 1'b0;
    @(posedge aclk);
    while (rv !== 1'b1) @(posedge aclk);
    rd_v = rdat;
    rres = rresp;
    rr <= 1'b0;
  endtask : rd
  task automatic st(input logic [10:0] e);
    rd(IEP_OFS_STAT);
    chk(32'(rd_v[18:8]), 32'(e));
  endtask : st
  task automatic ack(input logic [1:0] n);
    @(posedge aclk);
    np <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    while (busy === 1'b1) @(posedge aclk);
  endtask : ack
  task automatic w12;
    repeat (12) @(posedge aclk);
  endtask : w12
  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awv, wv, br, arv, rr, go} = 7'h00;
    {aa, ra, req, np, wd} = 58'h0;
    {err_count, checks, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IEP_OFS_MASK);
    chk(rd_v, 32'h0000_0000);
    st({3'h7, 8'h00});
    wr(IEP_OFS_MASK, 32'h0000_01a5);
    rd(IEP_OFS_MASK);
    chk(rd_v, 32'h0000_00a5);
    wr(IEP_OFS_MASK, 32'h0000_0000);
    rd(8'h18);
    chk(32'(rres), 32'(IEP_RESP_ERR));
    wr(8'h1c, 32'h0000_0001);
    chk(32'(bres), 32'(IEP_RESP_ERR));
    req <= 8'h28;
    w12;
    chk(int_req, 1'b1);
    ack(3);
    chk(ack_level, 3'h3);
    req <= 8'h20;
    w12;
    chk(int_req, 1'b0);
    st({3'h7, 8'h08});
    wr(IEP_OFS_CMD, 32'h0000_0010);
    w12;
    chk(int_req, 1'b1);
    ack(3);
    chk(ack_level, 3'h5);
    req <= 8'h00;
    wr(IEP_OFS_CMD, 32'h0000_0025);
    st({3'h7, 8'h00});
    wr(IEP_OFS_MASK, 32'h0000_0001);
    req <= 8'h01;
    w12;
    chk(int_req, 1'b0);
    st({3'h7, 8'h00});
    chk(32'(rd_v[7:0]), 32'h0000_0001);
    wr(IEP_OFS_MASK, 32'h0000_0000);
    w12;
    chk(int_req, 1'b1);
    ack(3);
    chk(ack_level, 3'h0);
    req <= 8'h00;
    wr(IEP_OFS_CMD, 32'h0000_0020);
    wr(IEP_OFS_MASK, 32'h0000_0001);
    req <= 8'h01;
    w12;
    req <= 8'h00;
    w12;
    wr(IEP_OFS_MASK, 32'h0000_0000);
    w12;
    chk(int_req, 1'b0);
    wr(IEP_OFS_CTRL, 32'h0000_0001);
    req <= 8'h04;
    w12;
    ack(1);
    req <= 8'h00;
    ack(1);
    st({3'h7, 8'h04});
    ack(1);
    st({3'h7, 8'h00});
    wr(IEP_OFS_CTRL, 32'h0000_0003);
    req <= 8'h02;
    w12;
    ack(1);
    req <= 8'h00;
    st({3'h7, 8'h02});
    ack(1);
    st({3'h7, 8'h00});
    req <= 8'h80;
    w12;
    chk(int_req, 1'b1);
    ack(1);
    req <= 8'h00;
    ack(1);
    wr(IEP_OFS_CTRL, 32'h0000_0000);
    req <= 8'h40;
    w12;
    ack(3);
    req <= 8'h10;
    w12;
    ack(3);
    chk(ack_level, 3'h4);
    req <= 8'h00;
    wr(IEP_OFS_CMD, 32'h0000_0030);
    st({3'h4, 8'h40});
    req <= 8'h21;
    w12;
    ack(3);
    chk(ack_level, 3'h5);
    req <= 8'h00;
    wr(IEP_OFS_CMD, 32'h0000_0025);
    wr(IEP_OFS_CMD, 32'h0000_0026);
    wr(IEP_OFS_CMD, 32'h0000_0047);
    req <= 8'h04;
    w12;
    ack(3);
    req <= 8'h80;
    w12;
    chk(int_req, 1'b0);
    wr(IEP_OFS_CMD, 32'h0000_0044);
    st({3'h4, 8'h04});
    w12;
    chk(int_req, 1'b0);
    wr(IEP_OFS_CMD, 32'h0000_0022);
    w12;
    chk(int_req, 1'b1);
    ack(3);
    chk(ack_level, 3'h7);
    req <= 8'h00;
    wr(IEP_OFS_CMD, 32'h0000_0057);
    st({3'h7, 8'h00});
    wr(IEP_OFS_CMD, 32'h0000_0060);
    rd(IEP_OFS_CTRL);
    chk(rd_v, 32'h0000_0004);
    req <= 8'h08;
    w12;
    ack(1);
    req <= 8'h00;
    ack(2);
    st({3'h3, 8'h00});
    wr(IEP_OFS_CMD, 32'h0000_0070);
    rd(IEP_OFS_ISTAT);
    chk(rd_v, 32'h0000_0007);
    chk(irq, 1'b0);
    wr(IEP_OFS_IMASK, 32'h0000_0007);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    wr(IEP_OFS_ISTAT, 32'h0000_0007);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    rd(IEP_OFS_ISTAT);
    chk(rd_v, 32'h0000_0000);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    st({3'h7, 8'h00});
    rd(IEP_OFS_IMASK);
    chk(rd_v, 32'h0000_0000);
    end_sim;
  end
endmodule : iep_top_tb
